// file: core/sar_adc_consts.vh
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH
// ==========================================================
// Register offsets
`define ADDR_STATUS_CONTROL 8'h38
`define ADDR_RESULT 8'h39
`define ADDR_CLOCK_SELECT 8'h3A
// ==========================================================
// Status and control fields
`define BIT_DONE 7
`define BIT_IRQ_ENABLE 6
`define BIT_CONTINUOUS 5
`define CHAN_MSB 4
`define CHAN_OFF 5'h1F
`define CHAN_COUNT 15
`define CHAN_HIGH_REF 5'h1D
`define CHAN_GROUND 5'h1E
`define RESET_STATUS_CONTROL 8'h1F
// ==========================================================
// Clock select fields
`define BIT_BUS_CLOCK 3
`define RESET_CLOCK_SELECT 8'h00
// ==========================================================
// Timing: 8 decisions plus setup, sample and finish steps
`define SAMPLE_STEPS 4'h7
`define CONV_STEPS_MIN 16
`define CONV_STEPS_MAX 17
`endif

// file: core/adc_clock_divider.v
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Converter clock enable divider
module adc_clock_divider (
  input wire mclk,
  input wire rst,
  input wire clear,
  input wire [2:0] divSelect,
  input wire extTick,
  input wire useBus,
  output reg tick
);
  reg [3:0] count;
  wire srcTick;
  wire [3:0] limit;
  assign srcTick = useBus ? 1'b1 : extTick;
  // Ratios 1, 2, 4, 8, then 16 for any select with top bit set
  assign limit = divSelect[2] ? 4'hF : ((4'h1 << divSelect[1:0]) - 4'h1);
  // Divider restarts on each new start so conversion length is steady
  always @(posedge mclk) begin
    if (rst || clear) begin
      count <= 4'h0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (srcTick) begin
        if (count >= limit) begin
          count <= 4'h0;
          tick <= 1'b1;
        end else begin
          count <= count + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: core/port_pin_share.v
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Port pin sharing between converter and general I/O
module port_pin_share #(
  parameter PINS = 15
) (
  input wire [PINS-1:0] claim,
  input wire [PINS-1:0] portLatch,
  input wire [PINS-1:0] portDir,
  input wire [PINS-1:0] pinIn,
  output wire [PINS-1:0] pinOut,
  output wire [PINS-1:0] pinOe,
  output wire [PINS-1:0] portRead
);
  genvar i;
  generate
    for (i = 0; i < PINS; i = i + 1) begin : gPin
      // Claimed pin never drives, whatever latch and direction say
      assign pinOut[i] = portLatch[i];
      assign pinOe[i] = portDir[i] & ~claim[i];
      // Claimed pin reads zero as input, latch as output
      assign portRead[i] = claim[i] ? (portDir[i] & portLatch[i]) :
                           (portDir[i] ? portLatch[i] : pinIn[i]);
    end
  endgenerate
endmodule
`default_nettype wire

// file: core/sar_adc_sequencer.v
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_consts.vh"
// Summary of operation
// - Status write starts conversion, 16-17 steps
// - One of 15 inputs feeds converter
// - Store result, then flag or interrupt
// - Selected pin forced to analog input
// - Claimed pin reads zero or latch
// - High reference FF, ground 00, linear
// - Continuous mode overwrites result, keeps converting
// - Flag read-only, cleared by write or read
// - With irq enable, done bit read/write
// - Interrupt after every conversion when enabled
// - Keep converting in wait; wake allowed
// - Stop mode aborts; restart needs a new status write
// - All-ones select powers converter off
// - Continuous clear means single conversion
// - Interrupt cleared by result read, status write
module sar_adc_sequencer #(
  parameter PINS = 15
) (
  input wire mclk,
  input wire rst,
  input wire [7:0] addr,
  input wire [7:0] wrData,
  input wire wrStrobe,
  input wire rdStrobe,
  output reg [7:0] rdData,
  input wire extClockTick,
  input wire stopMode,
  input wire waitMode,
  input wire comparatorHigh,
  output reg [7:0] trialCode,
  output reg [4:0] muxSelect,
  output reg sampleHold,
  output reg analogPowerOn,
  output reg conversionIrq,
  output wire wakeRequest,
  input wire [PINS-1:0] portLatch,
  input wire [PINS-1:0] portDir,
  input wire [PINS-1:0] pinIn,
  output wire [PINS-1:0] pinOut,
  output wire [PINS-1:0] pinOe,
  output wire [PINS-1:0] portRead
);
  // ==========================================================
  // States
  localparam IDLE = 2'b00;
  localparam SAMPLE = 2'b01;
  localparam RESOLVE = 2'b10;
  localparam FINISH = 2'b11;

  reg conversion_done_flag;
  reg conversion_irq_enable;
  reg continuous_conversion_enable;
  reg [4:0] input_channel_select;
  reg [7:0] result;
  reg [7:0] clockSelect;
  reg [1:0] state;
  reg [3:0] stepCount;
  reg [2:0] bitIndex;
  reg [7:0] approx;
  reg [14:0] claimVec;
  wire stepTick;
  wire statusWrite;
  wire resultRead;
  wire powerOff;
  wire stepEnable;
  wire endConversion;
  wire [7:0] statusRead;

  assign statusWrite = wrStrobe && (addr == `ADDR_STATUS_CONTROL);
  assign resultRead = rdStrobe && (addr == `ADDR_RESULT);
  assign powerOff = (input_channel_select == `CHAN_OFF);
  // Wait mode has no effect here; stop and the off channel freeze the sequencer
  assign stepEnable = stepTick && !stopMode && !powerOff;
  assign endConversion = (state == FINISH) && stepEnable;
  // Enabled request may wake the processor from wait
  assign wakeRequest = waitMode && conversionIrq;

  // ==========================================================
  // Converter clock
  adc_clock_divider uDivider (
    .mclk(mclk),
    .rst(rst),
    .clear(statusWrite),
    .divSelect(clockSelect[2:0]),
    .extTick(extClockTick),
    .useBus(clockSelect[`BIT_BUS_CLOCK]),
    .tick(stepTick)
  );

  // ==========================================================
  // Pin claim follows the routed mux channel so the pin and the mux never disagree
  always @* begin
    claimVec = 15'h0000;
    if (muxSelect != `CHAN_OFF && muxSelect < `CHAN_COUNT) begin
      claimVec[muxSelect[3:0]] = 1'b1;
    end
  end

  port_pin_share #(.PINS(PINS)) uPins (
    .claim(claimVec[PINS-1:0]),
    .portLatch(portLatch),
    .portDir(portDir),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .portRead(portRead)
  );

  // ==========================================================
  // Analog side controls
  always @(posedge mclk) begin
    if (rst) begin
      muxSelect <= `CHAN_OFF;
      analogPowerOn <= 1'b0;
    end else begin
      muxSelect <= input_channel_select;
      // Stop mode powers the analog side down as well
      analogPowerOn <= !powerOff && !stopMode;
    end
  end

  // ==========================================================
  // Register writes and flags
  always @(posedge mclk) begin
    if (rst) begin
      conversion_done_flag <= 1'b0;
      conversion_irq_enable <= 1'b0;
      continuous_conversion_enable <= 1'b0;
      input_channel_select <= `CHAN_OFF;
      clockSelect <= `RESET_CLOCK_SELECT;
      result <= 8'h00;
      conversionIrq <= 1'b0;
    end else begin
      if (statusWrite) begin
        conversion_irq_enable <= wrData[`BIT_IRQ_ENABLE];
        continuous_conversion_enable <= wrData[`BIT_CONTINUOUS];
        input_channel_select <= wrData[`CHAN_MSB:0];
      end
      if (wrStrobe && addr == `ADDR_CLOCK_SELECT) begin
        clockSelect <= wrData;
      end
      // Completion wins over a clear in the same cycle
      if (endConversion) begin
        result <= approx;
        if (!conversion_irq_enable) begin
          conversion_done_flag <= 1'b1;
        end
        conversionIrq <= conversion_irq_enable;
      end else if (statusWrite || resultRead) begin
        conversionIrq <= 1'b0;
        if (statusWrite && wrData[`BIT_IRQ_ENABLE]) begin
          conversion_done_flag <= wrData[`BIT_DONE];
        end else if (!conversion_irq_enable || statusWrite) begin
          conversion_done_flag <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Successive approximation sequencer
  always @(posedge mclk) begin
    if (rst) begin
      state <= IDLE;
      stepCount <= 4'h0;
      bitIndex <= 3'h7;
      approx <= 8'h00;
      trialCode <= 8'h00;
      sampleHold <= 1'b0;
    end else if (statusWrite) begin
      // Any status write abandons work; it starts afresh unless the channel is off
      state <= (wrData[`CHAN_MSB:0] == `CHAN_OFF) ? IDLE : SAMPLE;
      stepCount <= 4'h0;
      bitIndex <= 3'h7;
      approx <= 8'h00;
      trialCode <= 8'h00;
      sampleHold <= 1'b0;
    end else if (stopMode && state != IDLE) begin
      // Abort; software must write again after stop ends
      state <= IDLE;
      sampleHold <= 1'b0;
      trialCode <= 8'h00;
    end else if (stepEnable) begin
      case (state)
        SAMPLE: begin
          sampleHold <= 1'b1;
          stepCount <= stepCount + 4'h1;
          if (stepCount == `SAMPLE_STEPS - 4'h1) begin
            state <= RESOLVE;
            trialCode <= 8'h80;
          end
        end
        RESOLVE: begin
          // Keep the trial bit while comparator says input is above
          approx[bitIndex] <= comparatorHigh;
          if (bitIndex == 3'h0) begin
            state <= FINISH;
            trialCode <= 8'h00;
          end else begin
            bitIndex <= bitIndex - 3'h1;
            trialCode <= (trialCode & ~(8'h01 << bitIndex)) |
                         ({7'h00, comparatorHigh} << bitIndex) |
                         (8'h01 << (bitIndex - 3'h1));
          end
        end
        FINISH: begin
          sampleHold <= 1'b0;
          stepCount <= 4'h0;
          bitIndex <= 3'h7;
          approx <= 8'h00;
          // Continuous mode loops straight back; single stops
          state <= continuous_conversion_enable ? SAMPLE : IDLE;
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Read path, data one cycle after strobe
  assign statusRead = {conversion_done_flag, conversion_irq_enable,
                       continuous_conversion_enable, input_channel_select};
  always @(posedge mclk) begin
    if (rst) begin
      rdData <= 8'h00;
    end else if (rdStrobe) begin
      case (addr)
        `ADDR_STATUS_CONTROL: rdData <= statusRead;
        `ADDR_RESULT: rdData <= result;
        `ADDR_CLOCK_SELECT: rdData <= {4'h0, clockSelect[3:0]};
        default: rdData <= 8'h00;
      endcase
    end else begin
      rdData <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// file: test/analog_front_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Analog multiplexer and comparator model
module analog_front_model (
  input wire logic [4:0] muxSelect,
  input wire logic [7:0] trialCode,
  input wire logic analogPowerOn,
  output logic comparatorHigh
);
  logic [7:0] level;
  // Input level per channel; references sit at the two ends of the scale
  always_comb begin
    if (muxSelect == 5'h1D) level = 8'hFF;
    else if (muxSelect == 5'h1E) level = 8'h00;
    else level = {muxSelect[3:0], ~muxSelect[3:0]};
  end
  // Powered down the decision is inverted, so a design that ignores power misconverts
  assign comparatorHigh = analogPowerOn ? (level >= trialCode) : (level < trialCode);
endmodule
`default_nettype wire

// file: test/sar_adc_sequencer_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checker
module sar_adc_sequencer_sva #(
  parameter PINS = 15
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic stopMode,
  input wire logic waitMode,
  input wire logic [7:0] trialCode,
  input wire logic [4:0] muxSelect,
  input wire logic analogPowerOn,
  input wire logic conversionIrq,
  input wire logic wakeRequest,
  input wire logic [PINS-1:0] portLatch,
  input wire logic [PINS-1:0] portDir,
  input wire logic [PINS-1:0] pinOe,
  input wire logic [PINS-1:0] portRead
);
  wire logic [3:0] ch;
  // Pin index of the selected channel
  assign ch = muxSelect[3:0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_wake; wakeRequest == (waitMode && conversionIrq); endproperty
  a_wake: assert property (p_wake) else $error("wake request wrong");
  property p_claim; muxSelect < 5'd15 |-> !pinOe[ch] && portRead[ch] == (portDir[ch] & portLatch[ch]); endproperty
  a_claim: assert property (p_claim) else $error("selected pin not claimed");
  property p_free; muxSelect == 5'h1F |-> pinOe == portDir; endproperty
  a_free: assert property (p_free) else $error("free pins not under port control");
  property p_off; muxSelect == 5'h1F |-> !analogPowerOn; endproperty
  a_off: assert property (p_off) else $error("converter powered while off");
  property p_off_write; wrStrobe && addr == 8'h38 && wrData[4:0] == 5'h1F |-> ##[1:2] !analogPowerOn; endproperty
  a_off_write: assert property (p_off_write) else $error("off write did not power down");
  property p_wr_clear; wrStrobe && addr == 8'h38 |=> !conversionIrq [*8]; endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("interrupt after status write");
  property p_rd_clear; rdStrobe && addr == 8'h39 |=> !conversionIrq; endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("interrupt after result read");
  property p_stop; stopMode && $past(stopMode) |-> $stable(trialCode) && !$rose(conversionIrq); endproperty
  a_stop: assert property (p_stop) else $error("activity in stop mode");
endmodule
`default_nettype wire

// file: test/sar_adc_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer_tb;
  logic mclk = 0, rst = 1, wrStrobe = 0, rdStrobe = 0, stopMode = 0, waitMode = 0;
  logic [7:0] addr = 0, wrData = 0, rdData, trialCode, v;
  logic [4:0] muxSelect, c;
  logic comparatorHigh, sampleHold, analogPowerOn, conversionIrq, wakeRequest;
  logic [14:0] portLatch = 15'h2AAA, portDir = 15'h0F0F, pinIn = 15'h1234, pinOut, pinOe, portRead;
  int err_count = 0, n_tests = 0, n;
  // ==========================================
  // Clock, design and analog model
  initial forever #25 mclk = ~mclk;
  sar_adc_sequencer dut (.mclk(mclk), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .extClockTick(1'b0), .stopMode(stopMode), .waitMode(waitMode),
    .comparatorHigh(comparatorHigh), .trialCode(trialCode), .muxSelect(muxSelect), .sampleHold(sampleHold),
    .analogPowerOn(analogPowerOn), .conversionIrq(conversionIrq), .wakeRequest(wakeRequest),
    .portLatch(portLatch), .portDir(portDir), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .portRead(portRead));
  analog_front_model front (.muxSelect(muxSelect), .trialCode(trialCode), .analogPowerOn(analogPowerOn),
    .comparatorHigh(comparatorHigh));
  // ==========================================
  // Bus tasks; a leading edge keeps strobes from being driven twice in one step
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge mclk);
    wrStrobe <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge mclk);
    rdStrobe <= 1'b0;
    #1 v = rdData;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(what, v, exp);
  endtask
  task automatic wait_irq;
    n = 0;
    while (conversionIrq !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  function automatic logic [7:0] level(input logic [4:0] s);
    return s == 5'h1D ? 8'hFF : s == 5'h1E ? 8'h00 : {s[3:0], ~s[3:0]};
  endfunction
  task automatic end_sim;
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  // Watchdog: the tests need about 700 cycles
  initial begin
    #(6000 * 50);
    err_count++;
    end_sim();
  end
  // ==========================================
  // Test sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rdc("status", 8'h38, 8'h1F);
    rdc("result", 8'h39, 8'h00);
    rdc("unmapped", 8'h40, 8'h00);
    wr(8'h3A, 8'h08);
    // Every channel in flag mode, then both references
    for (int ch = 0; ch < 17; ch++) begin
      c = (ch < 15) ? ch[4:0] : ch[4:0] + 5'd14;
      wr(8'h38, {3'b000, c});
      for (int k = 0; k < 30 && v[7] !== 1'b1; k++) rd(8'h38);
      check("done", v, {3'b100, c});
      if (ch < 15) check("pin oe", pinOe[ch], 1'b0);
      if (ch < 15) check("pin read", portRead[ch], portDir[ch] & portLatch[ch]);
      rdc("level", 8'h39, level(c));
      rdc("cleared", 8'h38, {3'b000, c});
    end
    // Interrupt mode with the processor waiting
    waitMode <= 1'b1;
    wr(8'h38, 8'h5D);
    wait_irq();
    check("time", n >= 15 && n <= 19, 1'b1);
    check("wake", wakeRequest, 1'b1);
    rdc("irq status", 8'h38, 8'h5D);
    rdc("irq result", 8'h39, 8'hFF);
    check("irq clr", conversionIrq, 1'b0);
    wr(8'h38, 8'hDD);
    rdc("done rw", 8'h38, 8'hDD);
    wait_irq();
    wr(8'h38, 8'h1F);
    check("irq wr clr", conversionIrq, 1'b0);
    waitMode <= 1'b0;
    // Continuous mode keeps overwriting; a write switches the channel
    wr(8'h38, 8'h7D);
    wait_irq();
    rdc("cont 1", 8'h39, 8'hFF);
    wait_irq();
    check("cont irq", conversionIrq, 1'b1);
    wr(8'h38, 8'h7E);
    wait_irq();
    rdc("cont 2", 8'h39, 8'h00);
    // Single shot after an abandoned start
    wr(8'h38, 8'h5E);
    repeat (5) @(posedge mclk);
    wr(8'h38, 8'h5D);
    wait_irq();
    rdc("restart", 8'h39, 8'hFF);
    repeat (40) @(posedge mclk);
    check("single", conversionIrq, 1'b0);
    // Stop mode aborts; settle 40 cycles, over two conversion periods, before a new start
    wr(8'h38, 8'h5E);
    repeat (5) @(posedge mclk);
    stopMode <= 1'b1;
    repeat (30) @(posedge mclk);
    stopMode <= 1'b0;
    repeat (40) @(posedge mclk);
    check("aborted", conversionIrq, 1'b0);
    wr(8'h38, 8'h5D);
    wait_irq();
    rdc("after stop", 8'h39, 8'hFF);
    end_sim();
  end
endmodule
bind sar_adc_sequencer sar_adc_sequencer_sva #(.PINS(PINS)) chk (.mclk(mclk), .rst(rst), .addr(addr),
  .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .stopMode(stopMode), .waitMode(waitMode),
  .trialCode(trialCode), .muxSelect(muxSelect), .analogPowerOn(analogPowerOn), .conversionIrq(conversionIrq),
  .wakeRequest(wakeRequest), .portLatch(portLatch), .portDir(portDir), .pinOe(pinOe), .portRead(portRead));
`default_nettype wire
